// ---- test_usb_device_interrupt_status_tree.sv ----
`timescale 1ns/10ps
module test_usb_device_interrupt_status_tree;
	localparam logic [7:0] A_TOP = {uist_pkg::IDX_TOP_SUMMARY, 2'b00};
	localparam logic [7:0] A_EP = {uist_pkg::IDX_EP_SUMMARY, 2'b00};
	localparam logic [7:0] A_EVT = {uist_pkg::IDX_BUS_EVENT, 2'b00};
	localparam logic [7:0] A_TEN = {uist_pkg::IDX_TOP_ENABLE, 2'b00};
	localparam logic [7:0] A_BEN = {uist_pkg::IDX_BUS_ENABLE, 2'b00};
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rdata;
	logic pready;
	logic pslverr;
	logic slverr;
	logic irq;
	logic [4:0] grp = 5'h00;
	logic [2:0] eps = 3'h0;
	logic [7:0] evt = 8'h00;
	logic reduced = 1'b0;
	logic setup = 1'b0;
	logic setaddr = 1'b0;
	logic [1:0] stall_clr;
	logic [1:0] nak_set;
	logic [1:0] tog_set;
	logic lock_set;
	logic [7:0] irq_count;
	int n_errors = 0;
	int checks = 0;

	always #4 clk = ~clk;

	uist_top dut (.CLOCK_IN(clk), .RESETN_IN(rstn), .CE_IN(ce),
		.PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
		.PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
		.PSLVERR_OUT(pslverr), .HOST_SIDE_PENDING_IN(grp[4]),
		.BUFFER_PENDING_IN(grp[3]), .BULK_PENDING_IN(grp[2]),
		.DISK_PORT_PENDING_IN(grp[1]), .CONTROL_ENDPOINT_PENDING_IN(grp[0]),
		.ENDPOINT_SUMMARY_IN(eps), .BUS_ENGINE_EVENT_IN(evt),
		.REDUCED_CLOCK_ACTIVE_STATE_IN(reduced), .SETUP_DONE_IN(setup),
		.SETUP_SET_ADDRESS_IN(setaddr), .FORCED_STALL_CLEAR_OUT(stall_clr),
		.FORCED_NAK_SET_OUT(nak_set), .TOGGLE_STATE_SET_OUT(tog_set),
		.CONTROL_ENDPOINT_LOCK_SET_OUT(lock_set), .IRQ_OUT(irq));

	uist_host_model host (.clk_in(clk), .resetn_in(rstn), .irq_in(irq),
		.irq_count_out(irq_count));

	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e) begin
			$display("[FAIL] %s expected %h seen %h", n, e, s);
			n_errors++;
		end
	endtask : chk

	// Called just after a rising edge; leaves one idle cycle behind
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdata = prdata;
		slverr = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		pwr <= 1'b0;
		@(posedge clk);
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rdc(input logic [7:0] a, input logic [31:0] e, input string n);
		apb(1'b0, a, 32'h0);
		chk(n, e, rdata);
	endtask : rdc

	task pulse(input logic [7:0] v);
		evt <= v;
		@(posedge clk);
		evt <= 8'h00;
		@(posedge clk);
	endtask : pulse

	task t_reset;
		for (int i = 0; i < 5; i++)
			rdc(8'(i * 4), 32'h0, "reset value");
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, slverr});
		chk("unmapped data", 32'h0, rdata);
		$display("test reset done");
	endtask : t_reset

	task t_setup;
		wr(A_TEN, 32'h01);
		setup <= 1'b1;
		setaddr <= 1'b1;
		@(posedge clk);
		setup <= 1'b0;
		setaddr <= 1'b0;
		@(posedge clk);
		rdc(A_TOP, 32'h0, "set address setup");
		setup <= 1'b1;
		@(posedge clk);
		setup <= 1'b0;
		#1;
		chk("ep update", 32'h7f, {stall_clr, nak_set, tog_set, lock_set});
		@(posedge clk);
		#1;
		chk("irq on setup", 32'h1, {31'h0, irq});
		chk("update ends", 32'h0, {stall_clr, nak_set, tog_set, lock_set});
		@(posedge clk);
		wr(A_TOP, 32'h0);
		rdc(A_TOP, 32'h1, "write zero keeps");
		wr(A_TOP, 32'h1);
		rdc(A_TOP, 32'h0, "write one clears");
		chk("irq drops", 32'h0, {31'h0, irq});
		$display("test setup done");
	endtask : t_setup

	task t_sources;
		wr(A_TEN, 32'hff);
		for (int i = 1; i < 6; i++) begin
			grp <= 5'h01 << (i - 1);
			@(posedge clk);
			rdc(A_TOP, 32'h1 << i, "group summary");
			chk("irq group", 32'h1, {31'h0, irq});
		end
		grp <= 5'h00;
		eps <= 3'h5;
		@(posedge clk);
		rdc(A_EP, 32'h5, "endpoint summary");
		wr(A_EP, 32'hff);
		wr(A_TOP, 32'hfe);
		rdc(A_TOP, 32'h40, "summary read only");
		eps <= 3'h0;
		@(posedge clk);
		rdc(A_TOP, 32'h0, "summary self clear");
		chk("irq idle", 32'h0, {31'h0, irq});
		$display("test sources done");
	endtask : t_sources

	task t_events;
		wr(A_BEN, 32'hff);
		for (int i = 0; i < 8; i++) begin
			pulse(8'h01 << i);
			rdc(A_EVT, 32'h1 << i, "event bit");
			rdc(A_TOP, 32'h80, "engine summary");
			wr(A_EVT, 32'h1 << i);
			rdc(A_EVT, 32'h0, "event cleared");
		end
		rdc(A_TOP, 32'h0, "engine self clear");
		pulse(8'hff);
		reduced <= 1'b1;
		wr(A_EVT, 32'hff);
		rdc(A_EVT, 32'h1f, "reduced clock clear");
		reduced <= 1'b0;
		wr(A_EVT, 32'h1f);
		rdc(A_EVT, 32'h0, "normal clear");
		wr(A_BEN, 32'h00);
		pulse(8'h01);
		rdc(A_TOP, 32'h0, "engine masked");
		wr(A_EVT, 32'h01);
		$display("test events done");
	endtask : t_events

	task t_freeze;
		ce <= 1'b0;
		pulse(8'h80);
		#1;
		chk("ready frozen", 32'h0, {31'h0, pready});
		chk("irq frozen", 32'h0, {31'h0, irq});
		@(posedge clk);
		ce <= 1'b1;
		@(posedge clk);
		rdc(A_EVT, 32'h0, "event lost while frozen");
		$display("test freeze done");
	endtask : t_freeze

	task complete_run;
		$display("Comparisons %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	// Whole run is a few hundred cycles
	initial begin
		repeat (5000) @(posedge clk);
		n_errors++;
		complete_run();
	end

	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_reset();
		t_setup();
		t_sources();
		t_events();
		t_freeze();
		chk("host saw irq", 32'h1, {31'h0, irq_count != 8'h00});
		complete_run();
	end
endmodule : test_usb_device_interrupt_status_tree

// ---- uist_host_model.sv ----
`timescale 1ns/10ps
module uist_host_model (
	// Clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// Interrupt line from the device
	input wire logic irq_in,
	output logic [7:0] irq_count_out
);
	logic irq_d_ff;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			irq_d_ff <= 1'b0;
			irq_count_out <= 8'h00;
		end else begin
			irq_d_ff <= irq_in;
			if (irq_in && !irq_d_ff)
				irq_count_out <= irq_count_out + 8'h01;
		end
	end
endmodule : uist_host_model

// ---- uist_pkg.sv ----
package uist_pkg;
	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_TOP_SUMMARY = 6'h00;
	localparam logic [5:0] IDX_EP_SUMMARY = 6'h01;
	localparam logic [5:0] IDX_BUS_EVENT = 6'h02;
	localparam logic [5:0] IDX_TOP_ENABLE = 6'h03;
	localparam logic [5:0] IDX_BUS_ENABLE = 6'h04;
	localparam int ADDR_IDX_LSB = 2;

	// Top summary bit positions
	localparam int TOP_BUS_ENGINE = 7;
	localparam int TOP_GENERAL_EP = 6;
	localparam int TOP_HOST_SIDE = 5;
	localparam int TOP_BUFFER = 4;
	localparam int TOP_BULK = 3;
	localparam int TOP_DISK_PORT = 2;
	localparam int TOP_CONTROL_EP = 1;
	localparam int TOP_SETUP_RECEIVED = 0;

	// Bus engine event bit positions
	localparam int EVT_SUPPLY_SENSE_CHANGED = 7;
	localparam int EVT_NON_IDLE_LINE_SEEN = 6;
	localparam int EVT_POWER_TRANSITION_DONE = 5;
	localparam int EVT_BUS_RESET_SEEN = 4;
	localparam int EVT_BUS_SUSPEND_SEEN = 3;
	localparam int EVT_SPEED_HANDSHAKE_DONE = 2;
	localparam int EVT_RESUME_RESTORE_DONE = 1;
	localparam int EVT_AUTO_ADDRESS_DONE = 0;

	// Events frozen against clearing in the reduced clock state
	localparam logic [7:0] EVT_SYNC_MASK = 8'h1f;

	// General endpoint summary: three live bits
	localparam int EP_COUNT = 3;
	localparam logic [7:0] EP_SUMMARY_MASK = 8'h07;

	// Reset values
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [7:0] RST_ENABLE = 8'h00;
	localparam logic [31:0] RST_RDATA = 32'h0000_0000;
endpackage : uist_pkg

// ---- uist_top.sv ----
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
module uist_top (
	// Clock, reset, clock enable
	input wire logic CLOCK_IN,
	input wire logic RESETN_IN,
	input wire logic CE_IN,
	// APB slave
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	// Subordinate groups: enabled cause pending
	input wire logic HOST_SIDE_PENDING_IN,
	input wire logic BUFFER_PENDING_IN,
	input wire logic BULK_PENDING_IN,
	input wire logic DISK_PORT_PENDING_IN,
	input wire logic CONTROL_ENDPOINT_PENDING_IN,
	input wire logic [2:0] ENDPOINT_SUMMARY_IN,
	// Bus engine event pulses
	input wire logic [7:0] BUS_ENGINE_EVENT_IN,
	input wire logic REDUCED_CLOCK_ACTIVE_STATE_IN,
	// Setup stage completion
	input wire logic SETUP_DONE_IN,
	input wire logic SETUP_SET_ADDRESS_IN,
	// Control endpoint updates, bit 1 IN, bit 0 OUT
	output logic [1:0] FORCED_STALL_CLEAR_OUT,
	output logic [1:0] FORCED_NAK_SET_OUT,
	output logic [1:0] TOGGLE_STATE_SET_OUT,
	output logic CONTROL_ENDPOINT_LOCK_SET_OUT,
	// Interrupt to the CPU
	output logic IRQ_OUT
);
	logic [5:0] idx;
	logic mapped;
	logic wr_access;
	logic rd_setup;
	logic [7:0] top_enable_ff;
	logic [7:0] bus_enable_ff;
	logic [7:0] bus_event_status;
	logic [7:0] bus_event_clr;
	logic setup_received;
	logic setup_clr;
	logic setup_accept;
	logic [7:0] top_summary;
	logic [7:0] ep_summary;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic irq_ff;
	logic [1:0] stall_clr_ff;
	logic [1:0] nak_set_ff;
	logic [1:0] toggle_set_ff;
	logic lock_set_ff;

	function automatic logic is_mapped(input logic [5:0] i);
		is_mapped = (i == uist_pkg::IDX_TOP_SUMMARY) ||
			(i == uist_pkg::IDX_EP_SUMMARY) ||
			(i == uist_pkg::IDX_BUS_EVENT) ||
			(i == uist_pkg::IDX_TOP_ENABLE) ||
			(i == uist_pkg::IDX_BUS_ENABLE);
	endfunction : is_mapped

	// Index from byte address; low address bits are ignored
	assign idx = PADDR_IN[7:uist_pkg::ADDR_IDX_LSB];
	assign mapped = is_mapped(idx);
	assign wr_access = PSEL_IN && PENABLE_IN && PWRITE_IN && CE_IN;
	assign rd_setup = PSEL_IN && !PENABLE_IN && !PWRITE_IN && CE_IN;

	// Zero wait states; frozen clock enable stalls the access
	assign PREADY_OUT = CE_IN;
	assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !mapped;

	assign setup_accept = SETUP_DONE_IN && !SETUP_SET_ADDRESS_IN;

	// Write one clears bit zero only
	assign setup_clr = wr_access && (idx == uist_pkg::IDX_TOP_SUMMARY) &&
		PWDATA_IN[uist_pkg::TOP_SETUP_RECEIVED];

	// Low events locked in reduced clock state
	always_comb begin
		bus_event_clr = '0;
		if (wr_access && (idx == uist_pkg::IDX_BUS_EVENT)) begin
			bus_event_clr = PWDATA_IN[7:0];
			if (REDUCED_CLOCK_ACTIVE_STATE_IN) begin
				bus_event_clr = PWDATA_IN[7:0] & ~uist_pkg::EVT_SYNC_MASK;
			end
		end
	end

	uist_w1c_bank #(
		.WIDTH(8)
	) u_bus_events (
		.clk_in(CLOCK_IN),
		.resetn_in(RESETN_IN),
		.ce_in(CE_IN),
		.set_in(BUS_ENGINE_EVENT_IN),
		.clr_in(bus_event_clr),
		.status_out(bus_event_status)
	);

	// Stored setup raises the direct cause
	uist_w1c_bank #(
		.WIDTH(1)
	) u_setup_received (
		.clk_in(CLOCK_IN),
		.resetn_in(RESETN_IN),
		.ce_in(CE_IN),
		.set_in(setup_accept),
		.clr_in(setup_clr),
		.status_out(setup_received)
	);

	assign ep_summary = {5'h00, ENDPOINT_SUMMARY_IN} &
		uist_pkg::EP_SUMMARY_MASK;

	// Source bits 1 to 6 are pure logic of the sources; bits 0 and 7 come from held status
	// Gate-only bus summary of held events; events pulsed while CE_IN is low are lost
	always_comb begin
		top_summary = '0;
		top_summary[uist_pkg::TOP_BUS_ENGINE] =
			|(bus_event_status & bus_enable_ff);
		top_summary[uist_pkg::TOP_GENERAL_EP] = |ep_summary;
		top_summary[uist_pkg::TOP_HOST_SIDE] = HOST_SIDE_PENDING_IN;
		top_summary[uist_pkg::TOP_BUFFER] = BUFFER_PENDING_IN;
		top_summary[uist_pkg::TOP_BULK] = BULK_PENDING_IN;
		top_summary[uist_pkg::TOP_DISK_PORT] = DISK_PORT_PENDING_IN;
		top_summary[uist_pkg::TOP_CONTROL_EP] = CONTROL_ENDPOINT_PENDING_IN;
		top_summary[uist_pkg::TOP_SETUP_RECEIVED] = setup_received;
	end

	always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			top_enable_ff <= uist_pkg::RST_ENABLE;
		end else if (wr_access && (idx == uist_pkg::IDX_TOP_ENABLE)) begin
			top_enable_ff <= PWDATA_IN[7:0];
		end
	end

	always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			bus_enable_ff <= uist_pkg::RST_ENABLE;
		end else if (wr_access && (idx == uist_pkg::IDX_BUS_ENABLE)) begin
			bus_enable_ff <= PWDATA_IN[7:0];
		end
	end

	// Read data caught in the setup cycle, stable through access
	always_comb begin
		nxt_rdata = uist_pkg::RST_RDATA;
		unique case (idx)
			uist_pkg::IDX_TOP_SUMMARY: nxt_rdata[7:0] = top_summary;
			uist_pkg::IDX_EP_SUMMARY: nxt_rdata[7:0] = ep_summary;
			uist_pkg::IDX_BUS_EVENT: nxt_rdata[7:0] = bus_event_status;
			uist_pkg::IDX_TOP_ENABLE: nxt_rdata[7:0] = top_enable_ff;
			uist_pkg::IDX_BUS_ENABLE: nxt_rdata[7:0] = bus_enable_ff;
			default: nxt_rdata = uist_pkg::RST_RDATA;
		endcase
	end

	always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			rdata_ff <= uist_pkg::RST_RDATA;
		end else if (rd_setup) begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign PRDATA_OUT = rdata_ff;

	// Assert on any enabled pending group
	// Negates once nothing enabled is pending
	always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			irq_ff <= 1'b0;
		end else if (CE_IN) begin
			irq_ff <= |(top_summary & top_enable_ff);
		end
	end

	assign IRQ_OUT = irq_ff;

	// Control endpoint update with the setup event
	always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			stall_clr_ff <= 2'h0;
			nak_set_ff <= 2'h0;
			toggle_set_ff <= 2'h0;
			lock_set_ff <= 1'b0;
		end else if (CE_IN) begin
			stall_clr_ff <= {2{setup_accept}};
			nak_set_ff <= {2{setup_accept}};
			toggle_set_ff <= {2{setup_accept}};
			lock_set_ff <= setup_accept;
		end
	end

	assign FORCED_STALL_CLEAR_OUT = stall_clr_ff;
	assign FORCED_NAK_SET_OUT = nak_set_ff;
	assign TOGGLE_STATE_SET_OUT = toggle_set_ff;
	assign CONTROL_ENDPOINT_LOCK_SET_OUT = lock_set_ff;

	chk_irq_raise: assert property (
		@(posedge CLOCK_IN) disable iff (!RESETN_IN)
		CE_IN && |(top_summary & top_enable_ff) |=> IRQ_OUT)
		else $error("irq not raised for enabled cause");

	chk_irq_drop: assert property (
		@(posedge CLOCK_IN) disable iff (!RESETN_IN)
		CE_IN && ((top_summary & top_enable_ff) == 8'h00) |=> !IRQ_OUT)
		else $error("irq stays high with nothing pending");

	chk_setup_sets: assert property (
		@(posedge CLOCK_IN) disable iff (!RESETN_IN)
		CE_IN && SETUP_DONE_IN && !SETUP_SET_ADDRESS_IN
		|=> top_summary[uist_pkg::TOP_SETUP_RECEIVED])
		else $error("setup received not set");

	chk_setaddr_quiet: assert property (
		@(posedge CLOCK_IN) disable iff (!RESETN_IN)
		CE_IN && SETUP_DONE_IN && SETUP_SET_ADDRESS_IN && !setup_received
		|=> !setup_received)
		else $error("set-address setup raised setup received");

	chk_ep0_update: assert property (
		@(posedge CLOCK_IN) disable iff (!RESETN_IN)
		CE_IN && setup_accept |=> (FORCED_NAK_SET_OUT == 2'h3) &&
		(FORCED_STALL_CLEAR_OUT == 2'h3) && (TOGGLE_STATE_SET_OUT == 2'h3) &&
		CONTROL_ENDPOINT_LOCK_SET_OUT)
		else $error("control endpoint not updated on setup");

	chk_setup_clear: assert property (
		@(posedge CLOCK_IN) disable iff (!RESETN_IN)
		setup_clr && !setup_accept |=> !setup_received)
		else $error("write one did not clear setup received");

	chk_zero_write: assert property (
		@(posedge CLOCK_IN) disable iff (!RESETN_IN)
		wr_access && (idx == uist_pkg::IDX_BUS_EVENT) &&
		(PWDATA_IN[7:0] == 8'h00) && (BUS_ENGINE_EVENT_IN == 8'h00)
		|=> $stable(bus_event_status))
		else $error("zero write changed bus events");

	chk_event_clear: assert property (
		@(posedge CLOCK_IN) disable iff (!RESETN_IN)
		wr_access && (idx == uist_pkg::IDX_BUS_EVENT) &&
		!REDUCED_CLOCK_ACTIVE_STATE_IN && (PWDATA_IN[7:0] == 8'hff) &&
		(BUS_ENGINE_EVENT_IN == 8'h00) |=> (bus_event_status == 8'h00))
		else $error("write ones did not clear bus events");

	chk_reduced_hold: assert property (
		@(posedge CLOCK_IN) disable iff (!RESETN_IN)
		wr_access && (idx == uist_pkg::IDX_BUS_EVENT) &&
		REDUCED_CLOCK_ACTIVE_STATE_IN
		|=> (bus_event_status[4:0] & $past(bus_event_status[4:0])) ==
		$past(bus_event_status[4:0]))
		else $error("low bus events cleared in reduced clock");

	chk_reserved_zero: assert property (
		@(posedge CLOCK_IN) disable iff (!RESETN_IN)
		rd_setup && (idx == uist_pkg::IDX_EP_SUMMARY)
		|=> (PRDATA_OUT[31:3] == 29'h0))
		else $error("reserved endpoint summary bits not zero");

	chk_bus_summary: assert property (
		@(posedge CLOCK_IN) disable iff (!RESETN_IN)
		CE_IN && BUS_ENGINE_EVENT_IN[uist_pkg::EVT_BUS_RESET_SEEN] &&
		bus_enable_ff[uist_pkg::EVT_BUS_RESET_SEEN] && top_enable_ff[7]
		|=> top_summary[uist_pkg::TOP_BUS_ENGINE] ##1 IRQ_OUT)
		else $error("bus engine event did not reach irq");
endmodule : uist_top

// ---- uist_w1c_bank.sv ----
`timescale 1ns/10ps
module uist_w1c_bank #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	// Hardware set pulses and software clear strobes
	input wire logic [WIDTH-1:0] set_in,
	input wire logic [WIDTH-1:0] clr_in,
	// Held status
	output logic [WIDTH-1:0] status_out
);
	logic [WIDTH-1:0] status_ff;
	logic [WIDTH-1:0] nxt_status;

	// Set wins over a clear in the same cycle
	always_comb begin
		nxt_status = (status_ff & ~clr_in) | set_in;
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			status_ff <= '0;
		end else if (ce_in) begin
			status_ff <= nxt_status;
		end
	end

	assign status_out = status_ff;
endmodule : uist_w1c_bank
